// [hdl/cdgc_clk_div.sv]
// tick divider whose ratio only changes at an output boundary
module cdgc_clk_div
  import cdgc_pkg::*;
#(
  parameter int CW = 10
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_tick,
  input  wire logic          i_bypass,
  input  wire logic [CW-1:0] i_ratio_m1,
  output logic               o_tick
);
  initial begin
    if (CW < 1 || CW > 16) $error("cdgc_clk_div: CW out of range");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] act_q;
  logic          byp_q;
  logic          tick_q;
  logic          wrap;

  // new ratio taken only at wrap, so no short period appears
  assign wrap   = i_tick && (byp_q || (cnt_q == act_q));
  assign o_tick = tick_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      act_q <= '0;
      byp_q <= 1'b0;
    end else if (wrap) begin
      cnt_q <= '0;
      act_q <= i_ratio_m1;
      byp_q <= i_bypass;
    end else if (i_tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) tick_q <= 1'b0;
    else          tick_q <= wrap;
  end

  // helper: ticks since the last boundary and the ratio then loaded
  logic [CW:0]   seen_q;
  logic [CW-1:0] want_q;
  logic          wbyp_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      seen_q <= '0;
      want_q <= '0;
      wbyp_q <= 1'b0;
    end else if (wrap) begin
      seen_q <= '0;
      want_q <= i_ratio_m1;
      wbyp_q <= i_bypass;
    end else if (i_tick) begin
      seen_q <= seen_q + 1'b1;
    end
  end

  div_period_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wrap && !wbyp_q |-> seen_q == {1'b0, want_q})
    else $error("divided period differs from loaded ratio");

  div_out_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_tick |-> $past(i_tick))
    else $error("divided tick without a source tick");
endmodule : cdgc_clk_div

// [hdl/cdgc_params.svh]
// constants for the clock divider and gating configuration block
`ifndef CDGC_PARAMS_SVH
`define CDGC_PARAMS_SVH
`define CDGC_ADDR_W        8
`define CDGC_OFF_GATE      8'h00
`define CDGC_OFF_XTAL      8'h04
`define CDGC_OFF_STAT      8'h08
`define CDGC_RST_GATE      16'h1000
`define CDGC_RST_XTAL      16'h08C1
`define CDGC_MASK_GATE     16'h1137
`define CDGC_MASK_XTAL     16'h2FFF
`define CDGC_BIT_VLO_AUTO  12
`define CDGC_BIT_SM_OFF    8
`define CDGC_SUB_CLOCK_DIVIDER_HI       5
`define CDGC_SUB_CLOCK_DIVIDER_LO       4
`define CDGC_MAIN_CLOCK_DIVIDER_HI       2
`define CDGC_MAIN_CLOCK_DIVIDER_LO       0
`define CDGC_BIT_FAULT_DIS 13
`define CDGC_AUX_CLOCK_DIVIDER_HI       11
`define CDGC_AUX_CLOCK_DIVIDER_LO       8
`define CDGC_DRV_HI        7
`define CDGC_DRV_LO        6
`define CDGC_BIT_XTS       5
`define CDGC_BIT_BYPASS    4
`define CDGC_HFF_HI        3
`define CDGC_HFF_LO        2
`define CDGC_BIT_AGC_OFF   1
`define CDGC_BIT_AUTO_OFF  0
`define CDGC_DRV_RST       2'h3
`define CDGC_SRC_XTAL      2'h0
`define CDGC_SRC_INTERNAL_REFERENCE_OSCILLATOR      2'h1
`define CDGC_SRC_VLO       2'h2
`define CDGC_RESP_OKAY     2'h0
`define CDGC_RESP_SLVERR   2'h2
`define CDGC_ADIV_M1_0     10'h000
`define CDGC_ADIV_M1_1     10'h00F
`define CDGC_ADIV_M1_2     10'h01F
`define CDGC_ADIV_M1_3     10'h03F
`define CDGC_ADIV_M1_4     10'h07F
`define CDGC_ADIV_M1_5     10'h0FF
`define CDGC_ADIV_M1_6     10'h17F
`define CDGC_ADIV_M1_7     10'h1FF
`define CDGC_ADIV_M1_8     10'h2FF
`define CDGC_ADIV_M1_9     10'h3FF
`define CDGC_ADIV_M1_10    10'h06B
`define CDGC_ADIV_M1_11    10'h151
`define CDGC_ADIV_M1_12    10'h19D
`define CDGC_ADIV_M1_13    10'h27F
`define CDGC_ADIV_ENH_LO   4'h8
`endif

// [hdl/cdgc_pkg.sv]
// types shared by the clock divider and gating configuration block
package cdgc_pkg;
  typedef logic [15:0] cdgc_reg_t;
  typedef logic [1:0]  cdgc_src_t;
  typedef logic [1:0]  cdgc_resp_t;
endpackage : cdgc_pkg

// [hdl/cdgc_top.sv]
// clock divider, gating and crystal configuration with an AXI4-Lite slave
`include "cdgc_params.svh"
module cdgc_top
  import cdgc_pkg::*;
#(
  parameter bit ENHANCED   = 1'b1,
  parameter bit HF_SUPPORT = 1'b1
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  input  wire logic [`CDGC_ADDR_W-1:0] i_awaddr,
  input  wire logic                    i_awvalid,
  output logic                         o_awready,
  input  wire logic [31:0]             i_wdata,
  input  wire logic [3:0]              i_wstrb,
  input  wire logic                    i_wvalid,
  output logic                         o_wready,
  output cdgc_resp_t                   o_bresp,
  output logic                         o_bvalid,
  input  wire logic                    i_bready,
  input  wire logic [`CDGC_ADDR_W-1:0] i_araddr,
  input  wire logic                    i_arvalid,
  output logic                         o_arready,
  output logic [31:0]                  o_rdata,
  output cdgc_resp_t                   o_rresp,
  output logic                         o_rvalid,
  input  wire logic                    i_rready,
  input  wire logic                    i_mclk_src_tick,
  input  wire logic                    i_xtal_tick,
  input  wire logic                    i_internal_reference_oscillator_tick,
  input  wire logic                    i_vlo_tick,
  input  wire cdgc_src_t               i_aclk_src_sel,
  input  wire logic                    i_xtal_fault,
  input  wire logic                    i_vlo_req,
  input  wire logic                    i_io_lock,
  output logic                         o_mclk_tick,
  output logic                         o_sub_main_clock_tick,
  output logic                         o_aclk_tick,
  output cdgc_src_t                    o_aclk_src_sel,
  output logic                         o_vlo_enable,
  output logic [1:0]                   o_xtal_drive,
  output logic                         o_xtal_hf_mode,
  output logic                         o_xtal_bypass,
  output logic [1:0]                   o_xtal_hf_freq,
  output logic                         o_xtal_agc_off,
  output logic                         o_xtal_auto_off
);
  initial begin
    if (`CDGC_ADDR_W < 4) $error("cdgc_top: address too narrow");
  end

  // ---------------- AXI4-Lite write side ----------------
  cdgc_reg_t                 gate_q;
  cdgc_reg_t                 xtal_q;
  logic [`CDGC_ADDR_W-1:0]   awaddr_q;
  logic [15:0]               wdata_q;
  logic [1:0]                wstrb_q;
  logic                      aw_have_q;
  logic                      w_have_q;
  logic                      bvalid_q;
  cdgc_resp_t                bresp_q;

  wire aw_take = i_awvalid && o_awready;
  wire w_take  = i_wvalid && o_wready;
  wire do_wr   = aw_have_q && w_have_q && !bvalid_q;
  wire wr_gate = (awaddr_q[`CDGC_ADDR_W-1:2] == `CDGC_OFF_GATE >> 2);
  wire wr_xtal = (awaddr_q[`CDGC_ADDR_W-1:2] == `CDGC_OFF_XTAL >> 2);
  wire wr_stat = (awaddr_q[`CDGC_ADDR_W-1:2] == `CDGC_OFF_STAT >> 2);
  wire [15:0] lane_m = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // mode bit is hardwired to 0 without high-frequency support
  wire [15:0] xts_bit  = 16'h0001 << `CDGC_BIT_XTS;
  wire [15:0] xtal_msk = HF_SUPPORT ? `CDGC_MASK_XTAL
                                    : (`CDGC_MASK_XTAL & ~xts_bit);
  // reserved positions never take a write
  wire [15:0] gate_wm = lane_m & `CDGC_MASK_GATE;
  wire [15:0] xtal_wm = lane_m & xtal_msk;
  wire [15:0] gate_d  = (gate_q & ~gate_wm) | (wdata_q & gate_wm);
  wire [15:0] xtal_d  = (xtal_q & ~xtal_wm) | (wdata_q & xtal_wm);

  assign o_awready = !aw_have_q;
  assign o_wready  = !w_have_q;
  assign o_bvalid  = bvalid_q;
  assign o_bresp   = bresp_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (aw_take) begin
      aw_have_q <= 1'b1;
      awaddr_q  <= i_awaddr;
    end else if (do_wr) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      w_have_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (w_take) begin
      w_have_q <= 1'b1;
      wdata_q  <= i_wdata[15:0];
      wstrb_q  <= i_wstrb[1:0];
    end else if (do_wr) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `CDGC_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_gate || wr_xtal || wr_stat) ? `CDGC_RESP_OKAY : `CDGC_RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // register bits reset; retention lives in the applied copy below
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      gate_q <= `CDGC_RST_GATE;
      xtal_q <= `CDGC_RST_XTAL;
    end else if (do_wr) begin
      if (wr_gate) gate_q <= gate_d;
      else if (wr_xtal) xtal_q <= xtal_d;
    end
  end

  // ---------------- field decode ----------------
  wire       vlo_auto  = gate_q[`CDGC_BIT_VLO_AUTO];
  wire       sm_off    = gate_q[`CDGC_BIT_SM_OFF];
  wire [1:0] sub_clock_divider      = gate_q[`CDGC_SUB_CLOCK_DIVIDER_HI:`CDGC_SUB_CLOCK_DIVIDER_LO];
  wire [2:0] main_clock_divider      = gate_q[`CDGC_MAIN_CLOCK_DIVIDER_HI:`CDGC_MAIN_CLOCK_DIVIDER_LO];
  wire       fault_dis = xtal_q[`CDGC_BIT_FAULT_DIS];
  wire [3:0] aux_clock_divider      = xtal_q[`CDGC_AUX_CLOCK_DIVIDER_HI:`CDGC_AUX_CLOCK_DIVIDER_LO];
  wire       crystal_freq_range_select       = xtal_q[`CDGC_BIT_XTS];

  // power-of-two ratios as counts minus one
  wire [6:0] main_clock_divider_m1 = 7'((8'h01 << main_clock_divider) - 8'h01);
  wire [2:0] sub_clock_divider_m1 = 3'((4'h1 << sub_clock_divider) - 4'h1);

  // unsupported codes fall back to divide-by-1
  function automatic logic [9:0] cdgc_adiv_m1(input logic [3:0] code, input logic enh);
    logic [9:0] r;
    r = `CDGC_ADIV_M1_0;
    case (code)
      4'h1: r = `CDGC_ADIV_M1_1;
      4'h2: r = `CDGC_ADIV_M1_2;
      4'h3: r = `CDGC_ADIV_M1_3;
      4'h4: r = `CDGC_ADIV_M1_4;
      4'h5: r = `CDGC_ADIV_M1_5;
      4'h6: r = `CDGC_ADIV_M1_6;
      4'h7: r = `CDGC_ADIV_M1_7;
      4'h8: r = enh ? `CDGC_ADIV_M1_8 : `CDGC_ADIV_M1_0;
      4'h9: r = enh ? `CDGC_ADIV_M1_9 : `CDGC_ADIV_M1_0;
      4'hA: r = enh ? `CDGC_ADIV_M1_10 : `CDGC_ADIV_M1_0;
      4'hB: r = enh ? `CDGC_ADIV_M1_11 : `CDGC_ADIV_M1_0;
      4'hC: r = enh ? `CDGC_ADIV_M1_12 : `CDGC_ADIV_M1_0;
      4'hD: r = enh ? `CDGC_ADIV_M1_13 : `CDGC_ADIV_M1_0;
      default: r = `CDGC_ADIV_M1_0;
    endcase
    return r;
  endfunction : cdgc_adiv_m1

  wire [9:0] aux_clock_divider_m1 = cdgc_adiv_m1(aux_clock_divider, ENHANCED);

  // ---------------- aux source selection ----------------
  // a faulty crystal is swapped for the internal reference
  wire       fallback = (i_aclk_src_sel == `CDGC_SRC_XTAL) && i_xtal_fault && !fault_dis;
  wire [1:0] src_eff  = fallback ? `CDGC_SRC_INTERNAL_REFERENCE_OSCILLATOR : i_aclk_src_sel;
  cdgc_src_t src_q;
  logic      aux_src_tick;
  always_comb begin
    aux_src_tick = i_internal_reference_oscillator_tick;
    case (src_q)
      `CDGC_SRC_XTAL: aux_src_tick = i_xtal_tick;
      `CDGC_SRC_VLO:  aux_src_tick = i_vlo_tick;
      default:        aux_src_tick = i_internal_reference_oscillator_tick;
    endcase
  end
  // divider only in high-frequency crystal mode, bypassed otherwise
  wire aux_bypass = !((src_q == `CDGC_SRC_XTAL) && crystal_freq_range_select);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) src_q <= `CDGC_SRC_INTERNAL_REFERENCE_OSCILLATOR;
    else          src_q <= src_eff;
  end
  assign o_aclk_src_sel = src_q;

  // ---------------- dividers ----------------
  logic mclk_tick;
  logic sm_raw_tick;
  logic sm_gate_q;

  cdgc_clk_div #(.CW(7)) u_mdiv (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_tick     (i_mclk_src_tick),
    .i_bypass   (1'b0),
    .i_ratio_m1 (main_clock_divider_m1),
    .o_tick     (mclk_tick)
  );

  cdgc_clk_div #(.CW(3)) u_sdiv (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_tick     (mclk_tick),
    .i_bypass   (1'b0),
    .i_ratio_m1 (sub_clock_divider_m1),
    .o_tick     (sm_raw_tick)
  );

  cdgc_clk_div #(.CW(10)) u_adiv (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_tick     (aux_src_tick),
    .i_bypass   (aux_bypass),
    .i_ratio_m1 (aux_clock_divider_m1),
    .o_tick     (o_aclk_tick)
  );

  // gate follows the register only at a sub-main tick, never mid-period
  always_ff @(posedge i_clk) begin
    if (!i_rst_n)         sm_gate_q <= 1'b0;
    else if (sm_raw_tick) sm_gate_q <= sm_off;
  end
  assign o_mclk_tick  = mclk_tick;
  assign o_sub_main_clock_tick = sm_raw_tick && !sm_gate_q;

  // ---------------- oscillator controls ----------------
  logic vlo_en_q;
  wire  vlo_used = (src_q == `CDGC_SRC_VLO) || i_vlo_req;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) vlo_en_q <= 1'b1;
    else          vlo_en_q <= !vlo_auto || vlo_used;
  end
  assign o_vlo_enable = vlo_en_q;

  // applied drive holds while io lock is high, even through reset
  logic [1:0] drv_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n && !i_io_lock) drv_q <= `CDGC_DRV_RST;
    else if (!i_io_lock)        drv_q <= xtal_q[`CDGC_DRV_HI:`CDGC_DRV_LO];
  end
  assign o_xtal_drive    = drv_q;
  assign o_xtal_hf_mode  = crystal_freq_range_select;
  assign o_xtal_bypass   = xtal_q[`CDGC_BIT_BYPASS];
  assign o_xtal_hf_freq  = xtal_q[`CDGC_HFF_HI:`CDGC_HFF_LO];
  assign o_xtal_agc_off  = xtal_q[`CDGC_BIT_AGC_OFF];
  assign o_xtal_auto_off = xtal_q[`CDGC_BIT_AUTO_OFF];

  // ---------------- AXI4-Lite read side ----------------
  logic       rvalid_q;
  logic [15:0] rdata_q;
  cdgc_resp_t rresp_q;
  wire  ar_take = i_arvalid && o_arready;
  wire  rd_gate = (i_araddr[`CDGC_ADDR_W-1:2] == `CDGC_OFF_GATE >> 2);
  wire  rd_xtal = (i_araddr[`CDGC_ADDR_W-1:2] == `CDGC_OFF_XTAL >> 2);
  wire  rd_stat = (i_araddr[`CDGC_ADDR_W-1:2] == `CDGC_OFF_STAT >> 2);
  wire [15:0] stat_w = {10'h000, sm_gate_q, drv_q, vlo_en_q, src_q};
  wire [15:0] rd_mux = rd_gate ? gate_q :
                       rd_xtal ? xtal_q :
                       rd_stat ? stat_w : 16'h0000;

  assign o_arready = !rvalid_q;
  assign o_rvalid  = rvalid_q;
  assign o_rdata   = {16'h0000, rdata_q};
  assign o_rresp   = rresp_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= `CDGC_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= (rd_gate || rd_xtal || rd_stat) ? `CDGC_RESP_OKAY : `CDGC_RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  logic rd_xtal_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n)     rd_xtal_q <= 1'b0;
    else if (ar_take) rd_xtal_q <= rd_xtal;
  end

  // ---------------- checks ----------------
  sequence gate_armed_s;
    sm_raw_tick && sm_off;
  endsequence

  vlo_on_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !vlo_auto |=> o_vlo_enable)
    else $error("oscillator off while auto-off clear");

  vlo_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    vlo_auto && !i_vlo_req && i_aclk_src_sel == `CDGC_SRC_XTAL && !fallback ##1
    vlo_auto && !i_vlo_req |-> ##1 !o_vlo_enable)
    else $error("unused oscillator left on");

  sm_stop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    gate_armed_s ##1 (sm_off [*2]) |-> !o_sub_main_clock_tick)
    else $error("sub-main tick while gated");

  fallback_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_aclk_src_sel == `CDGC_SRC_XTAL && i_xtal_fault && !fault_dis
    |=> o_aclk_src_sel == `CDGC_SRC_INTERNAL_REFERENCE_OSCILLATOR)
    else $error("no fallback on crystal fault");

  no_fallback_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_aclk_src_sel == `CDGC_SRC_XTAL && fault_dis |=> o_aclk_src_sel == `CDGC_SRC_XTAL)
    else $error("fallback taken while disabled");

  aux_byp_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (src_q == `CDGC_SRC_XTAL && !crystal_freq_range_select) [*3] |-> o_aclk_tick == $past(i_xtal_tick))
    else $error("aux divider not bypassed in low-frequency mode");

  xts_ro_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !HF_SUPPORT |-> !o_xtal_hf_mode)
    else $error("crystal mode bit set without support");

  rsvd_rd_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ar_take && (rd_gate || rd_xtal)
    |=> (o_rdata & ~{16'h0000, (rd_xtal_q ? xtal_msk : `CDGC_MASK_GATE)}) == 32'h0)
    else $error("reserved bits read nonzero");

  drv_hold_a: assert property (@(posedge i_clk)
    i_io_lock |=> $stable(o_xtal_drive))
    else $error("drive strength changed under io lock");

  drv_rst_a: assert property (@(posedge i_clk)
    !i_rst_n && !i_io_lock |=> o_xtal_drive == `CDGC_DRV_RST)
    else $error("drive strength not at reset value");
endmodule : cdgc_top

// [testbench/cdgc_top_bench.sv]
// self-checking bench for the clock divider and gating configuration block
`include "cdgc_params.svh"
module cdgc_top_bench
  import cdgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    logic [7:0]  addr;
    logic [3:0]  strb;
    logic [31:0] wdata;
    cdgc_resp_t  bresp;
    logic [31:0] rdata;
  } cdgc_row_s;

  localparam int NROW = 8;
  localparam int ARAT [16] = '{1, 16, 32, 64, 128, 256, 384, 512, 768, 1024, 108, 338, 414,
                               640, 1, 1};

  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, o_rdata, got_data, o_rdata2, got_data2;
  logic [3:0]  wstrb;
  logic        mtick, xtick, rtick, vtick, fault, vreq, lock;
  cdgc_src_t   asel, o_asel;
  cdgc_resp_t  o_bresp, o_rresp, got_resp;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic        o_mclk, o_sub_main_clock, o_aclk, o_vlo_en, o_hf, o_hf2, o_byp, o_agc, o_aoff;
  logic [1:0]  o_drive, o_hff;
  int          failures, n_tests, mc, sc, ac;
  cdgc_row_s   rows [NROW];

  cdgc_top i_cdgc_top (
    .i_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(o_awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(rready), .i_mclk_src_tick(mtick),
    .i_xtal_tick(xtick), .i_internal_reference_oscillator_tick(rtick), .i_vlo_tick(vtick), .i_aclk_src_sel(asel),
    .i_xtal_fault(fault), .i_vlo_req(vreq), .i_io_lock(lock), .o_mclk_tick(o_mclk),
    .o_sub_main_clock_tick(o_sub_main_clock), .o_aclk_tick(o_aclk), .o_aclk_src_sel(o_asel),
    .o_vlo_enable(o_vlo_en), .o_xtal_drive(o_drive), .o_xtal_hf_mode(o_hf),
    .o_xtal_bypass(o_byp), .o_xtal_hf_freq(o_hff), .o_xtal_agc_off(o_agc),
    .o_xtal_auto_off(o_aoff)
  );

  // second copy without high-frequency support, fed by the same bus
  cdgc_top #(.HF_SUPPORT(1'b0)) i_cdgc_top_nohf (
    .i_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(), .o_bresp(), .o_bvalid(), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(), .o_rdata(o_rdata2),
    .o_rresp(), .o_rvalid(), .i_rready(rready), .i_mclk_src_tick(mtick),
    .i_xtal_tick(xtick), .i_internal_reference_oscillator_tick(rtick), .i_vlo_tick(vtick), .i_aclk_src_sel(asel),
    .i_xtal_fault(fault), .i_vlo_req(vreq), .i_io_lock(lock), .o_mclk_tick(),
    .o_sub_main_clock_tick(), .o_aclk_tick(), .o_aclk_src_sel(),
    .o_vlo_enable(), .o_xtal_drive(), .o_xtal_hf_mode(o_hf2),
    .o_xtal_bypass(), .o_xtal_hf_freq(), .o_xtal_agc_off(), .o_xtal_auto_off()
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic hang;
    failures++;
    $display("ERROR t=%0t bus wait ran out got=%h exp=%h", $time, 1'b0, 1'b1);
    stop_test();
  endtask : hang

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_cnt(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      failures++;
      $display("ERROR t=%0t count got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_cnt

  // bready held from the start; response captured before it is released
  task automatic axi_write(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int k;
    logic ta, tw, tb;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(negedge clk);
      ta = awvalid && o_awready;
      tw = wvalid && o_wready;
      tb = bready && o_bvalid;
      if (tb) got_resp = o_bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        break;
      end
    end
    if (k == 64) hang();
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    int k;
    logic ta, tr;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(negedge clk);
      ta = arvalid && o_arready;
      tr = rready && o_rvalid;
      if (tr) got_data = o_rdata;
      if (tr) got_data2 = o_rdata2;
      if (tr) got_resp = o_rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        break;
      end
    end
    if (k == 64) hang();
  endtask : axi_read

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic count_ticks(input int n);
    mc = 0;
    sc = 0;
    ac = 0;
    repeat (n) begin
      @(negedge clk);
      if (o_mclk === 1'b1) mc++;
      if (o_sub_main_clock === 1'b1) sc++;
      if (o_aclk === 1'b1) ac++;
    end
    // back on a rising edge so later stimulus is not driven mid-cycle
    @(posedge clk);
  endtask : count_ticks

  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    idle(16);
    rst_n <= 1'b1;
  endtask : do_reset

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, fault, vreq, lock} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {mtick, xtick, rtick, vtick} = 4'hF;
    asel = `CDGC_SRC_INTERNAL_REFERENCE_OSCILLATOR;
    failures = 0;
    n_tests = 0;
    rows[0] = '{`CDGC_OFF_GATE, 4'hF, 32'hFFFF_FFFF, `CDGC_RESP_OKAY, 32'h0000_1137};
    rows[1] = '{`CDGC_OFF_XTAL, 4'hF, 32'hFFFF_FFFF, `CDGC_RESP_OKAY, 32'h0000_2FFF};
    rows[2] = '{`CDGC_OFF_GATE, 4'hF, 32'h0000_0000, `CDGC_RESP_OKAY, 32'h0000_0000};
    rows[3] = '{`CDGC_OFF_GATE, 4'h1, 32'h0000_FFFF, `CDGC_RESP_OKAY, 32'h0000_0037};
    rows[4] = '{8'h0C, 4'hF, 32'h0000_FFFF, `CDGC_RESP_SLVERR, 32'h0000_0000};
    rows[5] = '{8'hFC, 4'hF, 32'h0000_FFFF, `CDGC_RESP_SLVERR, 32'h0000_0000};
    rows[6] = '{`CDGC_OFF_XTAL, 4'hF, 32'h0000_08C1, `CDGC_RESP_OKAY, 32'h0000_08C1};
    rows[7] = '{`CDGC_OFF_XTAL, 4'hF, 32'h0000_003E, `CDGC_RESP_OKAY, 32'h0000_003E};
    idle(16);
    rst_n <= 1'b1;
    cmp_val({30'h0, o_drive}, 32'h3);
    axi_read(`CDGC_OFF_GATE);
    cmp_val(got_data, 32'h0000_1000);
    axi_read(`CDGC_OFF_XTAL);
    cmp_val(got_data, 32'h0000_08C1);
    cmp_val({26'h0, o_hf, o_byp, o_hff, o_agc, o_aoff}, 32'h01);
    $display("reset values done");
    for (int i = 0; i < NROW; i++) begin
      axi_write(rows[i].addr, rows[i].strb, rows[i].wdata);
      cmp_val({30'h0, got_resp}, {30'h0, rows[i].bresp});
      axi_read(rows[i].addr);
      cmp_val(got_data, rows[i].rdata);
      cmp_val({30'h0, got_resp}, {30'h0, rows[i].bresp});
    end
    cmp_val({26'h0, o_hf, o_byp, o_hff, o_agc, o_aoff}, 32'h3E);
    cmp_val(got_data2, 32'h0000_001E);
    cmp_val({31'h0, o_hf2}, 32'h0);
    $display("register table done");
    // settle waits cover the longest old period before counting
    for (int k = 0; k < 8; k++) begin
      axi_write(`CDGC_OFF_GATE, 4'hF, 32'h0000_1000 | 32'(k));
      idle(300);
      count_ticks(1024);
      cmp_cnt(mc, 1024 >> k);
      cmp_cnt(sc, 1024 >> k);
    end
    for (int s = 0; s < 4; s++) begin
      axi_write(`CDGC_OFF_GATE, 4'hF, 32'h0000_1001 | 32'(s << 4));
      idle(300);
      count_ticks(1024);
      cmp_cnt(sc, 512 >> s);
    end
    axi_write(`CDGC_OFF_GATE, 4'hF, 32'h0000_1111);
    idle(300);
    count_ticks(1024);
    cmp_cnt(sc, 0);
    cmp_cnt(mc, 512);
    axi_write(`CDGC_OFF_GATE, 4'hF, 32'h0000_1011);
    idle(300);
    count_ticks(1024);
    cmp_cnt(sc, 256);
    $display("main and sub-main dividers done");
    asel <= `CDGC_SRC_XTAL;
    for (int c = 0; c < 16; c++) begin
      axi_write(`CDGC_OFF_XTAL, 4'hF, 32'h0000_00E1 | 32'(c << 8));
      idle(1100);
      count_ticks(4 * ARAT[c]);
      cmp_cnt(ac, 4);
    end
    cmp_val({31'h0, o_hf}, 32'h1);
    axi_write(`CDGC_OFF_XTAL, 4'hF, 32'h0000_07C1);
    idle(1100);
    count_ticks(64);
    cmp_cnt(ac, 64);
    cmp_val({31'h0, o_hf}, 32'h0);
    $display("aux divider done");
    fault <= 1'b1;
    idle(3);
    cmp_val({30'h0, o_asel}, {30'h0, `CDGC_SRC_INTERNAL_REFERENCE_OSCILLATOR});
    axi_write(`CDGC_OFF_XTAL, 4'hF, 32'h0000_28C1);
    idle(3);
    cmp_val({30'h0, o_asel}, {30'h0, `CDGC_SRC_XTAL});
    fault <= 1'b0;
    $display("fault fallback done");
    asel <= `CDGC_SRC_INTERNAL_REFERENCE_OSCILLATOR;
    idle(3);
    cmp_val({31'h0, o_vlo_en}, 32'h0);
    asel <= `CDGC_SRC_VLO;
    idle(3);
    cmp_val({31'h0, o_vlo_en}, 32'h1);
    asel <= `CDGC_SRC_INTERNAL_REFERENCE_OSCILLATOR;
    vreq <= 1'b1;
    idle(3);
    cmp_val({31'h0, o_vlo_en}, 32'h1);
    vreq <= 1'b0;
    axi_write(`CDGC_OFF_GATE, 4'hF, 32'h0000_0000);
    idle(3);
    cmp_val({31'h0, o_vlo_en}, 32'h1);
    $display("oscillator auto-off done");
    // lock held across a reset: applied drive survives, register does not
    axi_write(`CDGC_OFF_XTAL, 4'hF, 32'h0000_0801);
    idle(3);
    cmp_val({30'h0, o_drive}, 32'h0);
    lock <= 1'b1;
    axi_write(`CDGC_OFF_XTAL, 4'hF, 32'h0000_0881);
    idle(3);
    cmp_val({30'h0, o_drive}, 32'h0);
    do_reset();
    axi_read(`CDGC_OFF_XTAL);
    cmp_val(got_data, 32'h0000_08C1);
    cmp_val({30'h0, o_drive}, 32'h0);
    axi_write(`CDGC_OFF_XTAL, 4'hF, 32'h0000_0841);
    lock <= 1'b0;
    idle(3);
    cmp_val({30'h0, o_drive}, 32'h1);
    $display("drive retention done");
    stop_test();
  end
endmodule : cdgc_top_bench
